// file: tap_defines.svh
// Purpose: constants for the boundary-scan test access logic
// Assumes: tap clock sampled by the 50 MHz system clock
// Notes:   included by the package and the design
//
// Overview of operation
// R1: instruction register is three bits, shifted in least significant bit first.
// R2: code 000 selects external test with the boundary chain between tdi and tdo.
// R3: external test capture loads input pin levels; shift moves them out.
// R4: external test drives output pins from chain values latched at update.
// R5: code 100 selects sample/preload; chain in path, normal pin path kept.
// R6: sample/preload capture takes current input and output values.
// R7: code 110 puts the identification register between tdi and tdo.
// R8: code 111 is bypass: one test clock of delay from tdi to tdo.
// R9: identification register is 32 bits wide.
// R10: identification register shifts out least significant bit first.
// R11: id bit 0 is one, 1-11 producer, 12-27 part, 28-31 revision.
// R12: bypass register is one flip-flop forming a one-stage serial path.
// R13: boundary chain is 98 bits, used only under external test or sample/preload.
// R14: each address/data pin owns an output cell (even) and input cell (odd), bits 0-15.
// R15: the external controller steers the state machine through mode select and test clock.
// R16: cell 16 sets pin direction: zero drives from output cells, one is high-z.
// R17: state machine follows the standard; unlisted codes select bypass.
`ifndef TAP_DEFINES_SVH
`define TAP_DEFINES_SVH
`define IR_W          3
`define IR_EXTEST     3'h0
`define IR_SAMPLE     3'h4
`define IR_IDCODE     3'h6
`define IR_BYPASS     3'h7
`define IR_CAPTURE    3'h1
`define ID_W          32
`define CHAIN_W       98
`define PAD_N         8
`define DIR_CELL      16
`define OTHER_W       81
`endif

// file: tap_pkg.sv
// Purpose: types for the boundary-scan test access logic
// Assumes: tap_defines.svh sizes the fields
// Notes:   one-hot controller states
`default_nettype none
`include "tap_defines.svh"
package tap_pkg;
  typedef enum logic [15:0] {
    TLR  = 16'h0001, RTI  = 16'h0002, SDRS = 16'h0004, CDR  = 16'h0008,
    SDR  = 16'h0010, E1DR = 16'h0020, PDR  = 16'h0040, E2DR = 16'h0080,
    UDR  = 16'h0100, SIRS = 16'h0200, CIR  = 16'h0400, SIR  = 16'h0800,
    E1IR = 16'h1000, PIR  = 16'h2000, E2IR = 16'h4000, UIR  = 16'h8000
  } tap_state_t;

  typedef struct packed {
    logic [2:0]          tck_s;
    logic [1:0]          tms_s;
    logic [1:0]          tdi_s;
    logic [1:0][7:0]     pad_s;
    tap_state_t          st;
    logic [`IR_W-1:0]    ir_sh;
    logic [`IR_W-1:0]    ir;
    logic                one_bit_bypass;
    logic [`ID_W-1:0]    id_sh;
    logic [`CHAIN_W-1:0] chain_sh;
    logic [`CHAIN_W-1:0] chain_upd;
    logic                tdo;
    logic                tdo_oe_n;
    logic [7:0]          ad_out;
    logic                ad_oe_n;
  } tap_regs_t;
endpackage : tap_pkg
`default_nettype wire

// file: jtag_boundary_scan_port.sv
// Purpose: boundary-scan test access port with id, bypass and 98-cell chain
// Assumes: test clock is far slower than clk; all tap pins are asynchronous
// Notes:   rising and falling test clock edges are found after a two-flop synchroniser
`timescale 1ns/1ps
`default_nettype none
`include "tap_defines.svh"
module jtag_boundary_scan_port
  import tap_pkg::*;
#(
  parameter logic [10:0] PRODUCER = 11'h055, // arbitrary
  parameter logic [15:0] PART     = 16'h1234, // arbitrary
  parameter logic [3:0]  REVISION = 4'h1     // arbitrary
) (
  // system
  input  wire logic                clk,
  input  wire logic                arst_n,
  // test access port pins
  input  wire logic                tck,
  input  wire logic                tms,
  input  wire logic                tdi,
  output var  logic                tdo,
  output var  logic                tdo_oe_n,
  // address/data pads
  input  wire logic [7:0]          muxed_addr_data_pin_in,
  output var  logic [7:0]          muxed_addr_data_pin_out,
  output var  logic                muxed_addr_data_pin_oe_n,
  // core side of the address/data pads
  input  wire logic [7:0]          core_ad_out,
  input  wire logic                core_ad_oe_n,
  // remaining chain cells: captured values and latched test values
  input  wire logic [`OTHER_W-1:0] other_cell_capture,
  output var  logic [`OTHER_W-1:0] other_cell_update,
  output var  logic                extest_active
);

  localparam logic [`ID_W-1:0] ID_VALUE = {REVISION, PART, PRODUCER, 1'b1}; // R9 R11

  tap_regs_t r;
  tap_regs_t n;

  logic rise;
  logic fall;
  logic tms_v;
  logic tdi_v;
  logic sel_chain;
  logic sel_id;
  logic sel_byp;
  logic [`CHAIN_W-1:0] cap;
  logic [`IR_W-1:0] ir_eff;

  always_comb begin
    n = r;
    n.tck_s = {r.tck_s[1:0], tck};
    n.tms_s = {r.tms_s[0], tms};
    n.tdi_s = {r.tdi_s[0], tdi};
    n.pad_s = {r.pad_s[0], muxed_addr_data_pin_in};
    rise  = r.tck_s[1] & ~r.tck_s[2];
    fall  = ~r.tck_s[1] & r.tck_s[2];
    tms_v = r.tms_s[1];
    tdi_v = r.tdi_s[1];

    // unlisted codes fall through to bypass
    unique case (r.ir)
      `IR_EXTEST, `IR_SAMPLE, `IR_IDCODE: ir_eff = r.ir; // R17
      default:                            ir_eff = `IR_BYPASS; // R17
    endcase
    sel_chain = (ir_eff == `IR_EXTEST) || (ir_eff == `IR_SAMPLE); // R2 R5 R13
    sel_id    = (ir_eff == `IR_IDCODE); // R7
    sel_byp   = (ir_eff == `IR_BYPASS); // R8

    // capture vector: pads then the remaining cells
    cap = '0;
    cap[`CHAIN_W-1:`DIR_CELL+1] = other_cell_capture;
    cap[`DIR_CELL] = r.ad_oe_n; // R6
    for (int i = 0; i < `PAD_N; i++) begin
      cap[2*i]   = r.ad_out[i]; // R6 R14
      cap[2*i+1] = r.pad_s[1][i]; // R3 R14
    end

    if (rise) begin
      // R15: the controller walks this machine with tms on each rising edge
      unique case (r.st)
        TLR:  n.st = tms_v ? TLR  : RTI;
        RTI:  n.st = tms_v ? SDRS : RTI;
        SDRS: n.st = tms_v ? SIRS : CDR;
        CDR:  n.st = tms_v ? E1DR : SDR;
        SDR:  n.st = tms_v ? E1DR : SDR;
        E1DR: n.st = tms_v ? UDR  : PDR;
        PDR:  n.st = tms_v ? E2DR : PDR;
        E2DR: n.st = tms_v ? UDR  : SDR;
        UDR:  n.st = tms_v ? SDRS : RTI;
        SIRS: n.st = tms_v ? TLR  : CIR;
        CIR:  n.st = tms_v ? E1IR : SIR;
        SIR:  n.st = tms_v ? E1IR : SIR;
        E1IR: n.st = tms_v ? UIR  : PIR;
        PIR:  n.st = tms_v ? E2IR : PIR;
        E2IR: n.st = tms_v ? UIR  : SIR;
        UIR:  n.st = tms_v ? SDRS : RTI;
        default: n.st = TLR;
      endcase

      unique case (r.st)
        CIR: n.ir_sh = `IR_CAPTURE; // R17
        SIR: n.ir_sh = {tdi_v, r.ir_sh[`IR_W-1:1]}; // R1
        CDR: begin
          if (sel_chain) n.chain_sh = cap; // R3 R6 R13
          if (sel_id) n.id_sh = ID_VALUE;
          if (sel_byp) n.one_bit_bypass = 1'b0;
        end
        SDR: begin
          if (sel_chain) n.chain_sh = {tdi_v, r.chain_sh[`CHAIN_W-1:1]};
          if (sel_id) n.id_sh = {tdi_v, r.id_sh[`ID_W-1:1]}; // R10
          if (sel_byp) n.one_bit_bypass = tdi_v; // R12
        end
        default: ;
      endcase
    end

    // update stages act on the falling edge, as the standard has it
    if (fall) begin
      unique case (r.st)
        // reset instruction on a falling edge too, so ir only moves there
        TLR: n.ir = `IR_IDCODE; // R17
        UIR: n.ir = r.ir_sh; // R1
        UDR: if (sel_chain) n.chain_upd = r.chain_sh; // R4 R13
        default: ;
      endcase
      unique case (r.st)
        SIR: begin
          n.tdo      = r.ir_sh[0];
          n.tdo_oe_n = 1'b0;
        end
        SDR: begin
          n.tdo_oe_n = 1'b0;
          if (sel_chain) n.tdo = r.chain_sh[0]; // R2 R5
          else if (sel_id) n.tdo = r.id_sh[0]; // R7 R10
          else n.tdo = r.one_bit_bypass; // R8 R12
        end
        default: n.tdo_oe_n = 1'b1;
      endcase
    end

    // pad drive: chain under external test, core otherwise
    if (ir_eff == `IR_EXTEST) begin
      for (int i = 0; i < `PAD_N; i++) n.ad_out[i] = r.chain_upd[2*i]; // R4 R14
      n.ad_oe_n = r.chain_upd[`DIR_CELL]; // R16
    end else begin
      n.ad_out  = core_ad_out; // R5
      n.ad_oe_n = core_ad_oe_n; // R5
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '0;
      r.st <= TLR;
      r.ir <= `IR_IDCODE;
      r.ir_sh <= `IR_CAPTURE;
      r.tdo_oe_n <= 1'b1;
      r.ad_oe_n <= 1'b1;
      r.chain_upd[`DIR_CELL] <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign tdo                      = r.tdo;
  assign tdo_oe_n                 = r.tdo_oe_n;
  assign muxed_addr_data_pin_out  = r.ad_out;
  assign muxed_addr_data_pin_oe_n = r.ad_oe_n;
  assign other_cell_update        = r.chain_upd[`CHAIN_W-1:`DIR_CELL+1];
  assign extest_active            = (r.ir == `IR_EXTEST);

endmodule // jtag_boundary_scan_port
`default_nettype wire

// file: jtag_boundary_scan_port_monitor.sv
// Purpose: port checks for the boundary-scan access logic
// Assumes: tck high and low for four clk each
// Notes:   tck edges reach outputs three to four clk late
`timescale 1ns/1ps
`default_nettype none
`include "tap_defines.svh"
module jtag_boundary_scan_port_monitor (
  // clock and reset
  input wire logic                clk,
  input wire logic                arst_n,
  // watched ports
  input wire logic                tck,
  input wire logic                tdo,
  input wire logic                tdo_oe_n,
  input wire logic [7:0]          muxed_addr_data_pin_out,
  input wire logic                muxed_addr_data_pin_oe_n,
  input wire logic [7:0]          core_ad_out,
  input wire logic                core_ad_oe_n,
  input wire logic [`OTHER_W-1:0] other_cell_update,
  input wire logic                extest_active
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_tdo; $changed(tdo) |-> !$past(tck, 3); endproperty
  a_tdo: assert property (p_tdo) else $error("tdo moved off a falling tck");
  property p_toe; $changed(tdo_oe_n) |-> !$past(tck, 3); endproperty
  a_toe: assert property (p_toe) else $error("tdo enable moved off a falling tck");
  property p_ext; $changed(extest_active) |-> !$past(tck, 3); endproperty
  a_ext: assert property (p_ext) else $error("instruction moved off a falling tck");
  property p_upd; $changed(other_cell_update) |-> !$past(tck, 3); endproperty
  a_upd: assert property (p_upd) else $error("update cells moved off a falling tck");
  property p_pad; extest_active && $changed(muxed_addr_data_pin_out) |-> !$past(tck, 4);
  endproperty
  a_pad: assert property (p_pad) else $error("test pad value moved off update");
  property p_pdir; extest_active && $changed(muxed_addr_data_pin_oe_n) |-> !$past(tck, 4);
  endproperty
  a_pdir: assert property (p_pdir) else $error("test pad direction moved off update");
  property p_pout; !extest_active && !$past(extest_active) && $past(arst_n)
    |-> muxed_addr_data_pin_out == $past(core_ad_out); endproperty
  a_pout: assert property (p_pout) else $error("pad value left the core path");
  property p_poe; !extest_active && !$past(extest_active) && $past(arst_n)
    |-> muxed_addr_data_pin_oe_n == $past(core_ad_oe_n); endproperty
  a_poe: assert property (p_poe) else $error("pad direction left the core path");
endmodule // jtag_boundary_scan_port_monitor
bind jtag_boundary_scan_port jtag_boundary_scan_port_monitor mon (.clk(clk), .arst_n(arst_n),
  .tck(tck), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .muxed_addr_data_pin_out(muxed_addr_data_pin_out),
  .muxed_addr_data_pin_oe_n(muxed_addr_data_pin_oe_n), .core_ad_out(core_ad_out),
  .core_ad_oe_n(core_ad_oe_n), .other_cell_update(other_cell_update),
  .extest_active(extest_active));
`default_nettype wire

// file: tap_host_model.sv
// Purpose: board test controller steering the test port
// Assumes: clk is the bench clock, 20 ns
// Notes:   tck idles low between steps, 160 ns period
`timescale 1ns/1ps
`default_nettype none
module tap_host_model (
  // bench clock
  input wire logic clk,
  // test port
  input wire logic tdo,
  output var logic tck,
  output var logic tms,
  output var logic tdi
);
  initial begin
    tck = 1'h0;
    tms = 1'h1;
    tdi = 1'h0;
  end
  task automatic step(input logic s, d, output logic q);
    tms = s;
    tdi = d;
    repeat (4) @(negedge clk);
    q = tdo;
    tck = 1'h1;
    repeat (4) @(negedge clk);
    tck = 1'h0;
  endtask
  task automatic walk(input logic [7:0] t, input int n);
    logic q;
    for (int i = 0; i < n; i++) step(t[i], 1'h0, q);
  endtask
  task automatic shift(input int n, input logic [127:0] din, output logic [127:0] dout);
    dout = '0;
    for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
  endtask
  task automatic ir(input logic [2:0] c, output logic [127:0] q);
    walk(8'h03, 4);
    shift(3, {125'h0, c}, q);
    walk(8'h01, 2);
  endtask
  task automatic dr(input int n, input logic [127:0] d, output logic [127:0] q);
    walk(8'h01, 3);
    shift(n, d, q);
    walk(8'h01, 2);
  endtask
endmodule // tap_host_model
`default_nettype wire

// file: jtag_boundary_scan_port_test.sv
// Purpose: self-checking bench for the boundary-scan access logic
// Assumes: design id parameters left at their defaults
// Notes:   inputs move on falling clk edges only
`timescale 1ns/1ps
`default_nettype none
`include "tap_defines.svh"
module jtag_boundary_scan_port_test;
  logic                clk, arst_n, tck, tms, tdi, tdo, tdo_oe_n, pad_oe_n, core_oe_n, ext;
  logic [7:0]          pad_in, pad_out, core_out;
  logic [`OTHER_W-1:0] cap, upd;
  logic [127:0]        got;
  int                  miscompares = 0;
  int                  num_checks = 0;
  jtag_boundary_scan_port DUT (.clk(clk), .arst_n(arst_n), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe_n(tdo_oe_n), .muxed_addr_data_pin_in(pad_in),
    .muxed_addr_data_pin_out(pad_out), .muxed_addr_data_pin_oe_n(pad_oe_n),
    .core_ad_out(core_out), .core_ad_oe_n(core_oe_n), .other_cell_capture(cap),
    .other_cell_update(upd), .extest_active(ext));
  // undriven tdo line is pulled up
  tap_host_model m (.clk(clk), .tdo(tdo_oe_n ? 1'h1 : tdo), .tck(tck), .tms(tms), .tdi(tdi));
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic [127:0] g, e);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  function automatic logic [127:0] cells(logic [7:0] o, i, logic d);
    cells = {30'h0, cap, 17'h0};
    cells[16] = d;
    for (int k = 0; k < 8; k++) begin
      cells[2*k] = o[k];
      cells[2*k+1] = i[k];
    end
  endfunction
  task automatic t_id();
    m.ir(3'h6, got);
    chk(got, 128'h1);
    m.dr(32, '0, got);
    chk(got, {96'h0, 4'h1, 16'h1234, 11'h055, 1'h1});
    $display("id test done");
  endtask
  task automatic t_byp();
    logic [2:0] c[5] = '{3'h7, 3'h1, 3'h2, 3'h3, 3'h5};
    foreach (c[k]) begin
      m.ir(c[k], got);
      chk(got, 128'h1);
      m.dr(9, 128'hA5, got);
      chk(got, 128'h14A);
    end
    $display("bypass test done");
  endtask
  task automatic t_ext();
    logic [127:0] pat;
    pat = cells(8'hC3, 8'h00, 1'h0);
    pat[97:17] = ~cap;
    m.ir(3'h0, got);
    chk(ext, 128'h1);
    m.dr(98, pat, got);
    chk({pad_oe_n, pad_out, upd}, {1'h0, 8'hC3, ~cap});
    m.dr(98, cells(8'h00, 8'h00, 1'h1), got);
    chk(got, cells(8'hC3, pad_in, 1'h0));
    chk(pad_oe_n, 128'h1);
    $display("extest test done");
  endtask
  task automatic t_smp();
    m.ir(3'h4, got);
    chk({ext, pad_out, pad_oe_n}, {1'h0, core_out, core_oe_n});
    m.dr(98, '0, got);
    chk(got, cells(core_out, pad_in, core_oe_n));
    $display("sample test done");
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    #500000;
    miscompares++;
    wrap_up();
  end
  initial begin
    arst_n = 1'h0;
    pad_in = 8'h5A;
    core_out = 8'h3C;
    core_oe_n = 1'h0;
    cap = {3{27'h5A3C0F1}};
    repeat (6) @(negedge clk);
    arst_n = 1'h1;
    repeat (4) @(negedge clk);
    m.walk(8'h1F, 6);
    t_id();
    t_byp();
    t_ext();
    t_smp();
    t_id();
    wrap_up();
  end
endmodule // jtag_boundary_scan_port_test
`default_nettype wire
